//--- rtl/mtg_pkg.sv
// Package: constants, types and register map of the motor thermal overload guard
`default_nettype none
package mtg_pkg;
  // AXI4-Lite register byte offsets
  localparam logic [7:0] OFS_FIRST_CUR = 8'h00;   // First rated current, 0.01 A units
  localparam logic [7:0] OFS_SECOND_CUR = 8'h04;  // Second rated current, 0.01 A units
  localparam logic [7:0] OFS_MOTOR_TYPE = 8'h08;  // Motor type code
  localparam logic [7:0] OFS_SECOND_TYPE = 8'h0c; // Second motor type code
  localparam logic [7:0] OFS_THERM_LVL = 8'h10;   // Thermistor trip level, 0.01 kohm units
  localparam logic [7:0] OFS_EXT_DISP = 8'h14;    // Extended display select
  localparam logic [7:0] OFS_SW_FREQ = 8'h18;     // Switching frequency select
  localparam logic [7:0] OFS_STATUS = 8'h1c;      // Status, read only
  localparam logic [7:0] OFS_ACCUM = 8'h20;       // Integrator value, read only
  localparam logic [7:0] OFS_CONTROL = 8'h24;     // Control: writes have no effect
  // Field encodings
  localparam logic [15:0] NOT_SET = 16'd9999;     // Setting "invalid" marker
  localparam logic [15:0] CUR_MAX = 16'd50000;    // 500.00 A
  localparam logic [15:0] CUR_RESET = 16'd2000;   // Drive rated current default, 20.00 A
  localparam logic [15:0] THERM_MIN = 16'd50;     // 0.5 kohm
  localparam logic [15:0] THERM_MAX = 16'd3000;   // 30 kohm
  localparam logic [15:0] FREQ_6HZ = 16'd600;     // 6 Hz in 0.01 Hz units
  localparam logic [3:0] SW_FREQ_MAX = 4'd15;
  // Integrator scale: 100% level = full model heat
  localparam logic [31:0] TRIP_LEVEL = 32'h0100_0000;
  localparam logic [31:0] PREALARM_LEVEL = 32'h00d9_999a; // 85% of trip level
  localparam logic [31:0] XSTR_LEVEL = 32'h0100_0000;     // Transistor heat trip level
  // Control tick
  localparam int TICK_NS = 100000;                      // 100 us tick
  localparam int CLK_NS = 10;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;
  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Integration mode per motor
  typedef enum logic [1:0] {MTG_INACTIVE, MTG_COOLING, MTG_ACTIVE} mtg_mode_e;
  // Software settings bundle
  typedef struct packed {
    logic [15:0] first_rated_current;
    logic [15:0] second_rated_current;
    logic [7:0] motor_type;
    logic [15:0] second_motor_type;
    logic [15:0] thermistor_trip_level;
    logic [7:0] extended_display_select;
    logic [3:0] switching_freq_select;
  } mtg_cfg_s;
endpackage : mtg_pkg
`default_nettype wire

//--- rtl/mtg_mode_sel.sv
// Mode selector: decides integration mode of both motors
`default_nettype none
module mtg_mode_sel
  import mtg_pkg::*;
(
  // Settings
  input wire logic [15:0] first_cur,
  input wire logic [15:0] second_cur,
  input wire logic [15:0] second_type,
  input wire logic second_set_select,
  // Modes
  output mtg_mode_e first_mode,
  output mtg_mode_e second_mode
);
  // Decoded setting conditions
  wire logic first_zero = (first_cur == 16'h0000);
  wire logic second_zero = (second_cur == 16'h0000);
  wire logic second_unset = (second_cur == NOT_SET);
  wire logic type_unset = (second_type == NOT_SET);
  wire logic both_unset = second_unset && type_unset;
  wire logic second_live = !second_zero && !second_unset;
  wire logic second_via_type = second_unset && !type_unset && !first_zero;
  // First motor: zero setting kills it, otherwise select moves it to cooling unless second current and type are both unset
  assign first_mode = first_zero ? MTG_INACTIVE :                           // see RL10
                      (!second_set_select || both_unset) ? MTG_ACTIVE : MTG_COOLING;
  // Second motor: only a live current, or a set type with second current unset and first current nonzero, enables it
  assign second_mode = (second_live || second_via_type) ?                   // see RL11
                       (second_set_select ? MTG_ACTIVE : MTG_COOLING) : MTG_INACTIVE;
endmodule // mtg_mode_sel
`default_nettype wire

//--- rtl/mtg_integrator.sv
// Thermal integrator for one motor model
`default_nettype none
module mtg_integrator
  import mtg_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Control
  input wire logic tick,
  input wire logic clear,
  input wire mtg_mode_e mode,
  input wire logic [15:0] rated_cur,
  input wire logic [15:0] meas_cur,
  input wire logic [3:0] decay_shift,
  // Accumulated heat
  output logic [31:0] accum_q
);
  logic [31:0] accum_d;
  // Current forced to zero while cooling
  wire logic [15:0] in_cur = (mode == MTG_ACTIVE) ? meas_cur : 16'h0000;   // see RL7 see RL8
  // Heat term: I^2 / Irated, forced to zero when the rating is zero 
  wire logic [31:0] i_sq = 32'(in_cur) * 32'(in_cur);
  wire logic [31:0] heat = (rated_cur == 16'h0000) ? 32'h0 : i_sq / 32'(rated_cur);
  // Cooling leak proportional to stored heat
  wire logic [31:0] leak = accum_q >> decay_shift;
  wire logic [32:0] sum = 33'(accum_q) + 33'(heat);
  wire logic [32:0] net = (sum > 33'(leak)) ? sum - 33'(leak) : 33'h0;
  // Next value: inactive mode holds the model at zero
  always_comb begin
    accum_d = accum_q;
    if (clear || mode == MTG_INACTIVE) begin // see RL9
      accum_d = 32'h0;
    end else if (tick) begin // see RL21
      accum_d = net[32] ? 32'hffff_ffff : net[31:0];
    end
  end
  // State register
  always_ff @(posedge core_clk) begin
    if (!rst_b) accum_q <= 32'h0;
    else accum_q <= accum_d;
  end
endmodule // mtg_integrator
`default_nettype wire

//--- rtl/mtg_guard.sv
// Top: motor thermal overload guard with AXI4-Lite register slave
// Functional notes
// RL1 - First rated current 0..500 A, defaults drive rating
// RL2 - First current zero disables first motor model
// RL3 - Operator sets 1.1x 60 Hz current
// RL4 - Second current 0..500 A, 9999 means invalid
// RL5 - Select input switches reference to second current
// RL6 - Select routed to terminal by operator code 3
// RL7 - Active state integrates measured current
// RL8 - Cooling state integrates zero current
// RL9 - Inactive state performs no protection
// RL10 - First motor mode from settings and select
// RL11 - Second motor mode from settings and select
// RL12 - Thermistor level 0.5..30 kohm, 9999 disables
// RL13 - Overheat trips output and latches
// RL14 - Trip clears only on reset input
// RL15 - Higher switching frequency shortens transistor trip
// RL16 - Constant-torque types allow full low-speed torque
// RL17 - Constant-torque curve applies from 6 Hz
// RL18 - Some settings writable only when display select 0
// RL19 - Prealarm at 85 percent, trip at 100
// RL20 - Prealarm alone never trips
// RL21 - Integrator steps once per control tick
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`default_nettype none
module mtg_guard
  import mtg_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Measurements and terminals
  input wire logic [15:0] output_current,
  input wire logic [15:0] output_freq,
  input wire logic [15:0] thermistor_ohms,
  input wire logic second_set_select,
  input wire logic reset_in,
  // Protective outputs
  output logic motor_overload_trip,
  output logic transistor_overheat_trip,
  output logic thermistor_trip,
  output logic overload_prealarm_out,
  output logic trip_out
);
  // Settings held by software
  mtg_cfg_s cfg_q, cfg_d;
  // AXI bookkeeping
  logic aw_hold_q, w_hold_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_d;
  logic [31:0] rdata_d;
  logic [1:0] rresp_d;
  // Tick counter
  logic [$clog2(TICK_CYCLES)-1:0] tick_cnt_q;
  logic tick_q;
  // Latched trips and registered prealarm
  logic motor_trip_q, xstr_trip_q, therm_trip_q, prealarm_q;
  mtg_mode_e first_mode, second_mode;
  logic [31:0] accum1, accum2, xstr_accum;

  // Merge a written word into a 16-bit field by byte strobes
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] st);
    merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction
  // Range check for current settings: 0..500 A or the invalid marker
  function automatic logic cur_ok(input logic [15:0] v, input logic allow_unset);
    cur_ok = (v <= CUR_MAX) || (allow_unset && v == NOT_SET);
  endfunction

  // Write is performed once both halves are held and response slot is free
  wire logic wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;
  wire logic ext_open = (cfg_q.extended_display_select == 8'h00);
  wire logic [15:0] wval = merge16(16'h0000, wdata_q, wstrb_q);
  wire logic therm_ok = (wval >= THERM_MIN && wval <= THERM_MAX) || wval == NOT_SET;
  wire logic rd_go = s_axi_arvalid && s_axi_arready;

  // Write decode: protected fields locked unless extended display is 0
  always_comb begin
    cfg_d = cfg_q;
    bresp_d = RESP_OKAY;
    case (awaddr_q)
      OFS_FIRST_CUR: begin
        if (cur_ok(merge16(cfg_q.first_rated_current, wdata_q, wstrb_q), 1'b0)) begin // see RL1
          cfg_d.first_rated_current = merge16(cfg_q.first_rated_current, wdata_q, wstrb_q);
        end else bresp_d = RESP_SLVERR;
      end
      OFS_SECOND_CUR: begin
        if (ext_open && cur_ok(wval, 1'b1)) cfg_d.second_rated_current = wval; // see RL4 see RL18
        else bresp_d = RESP_SLVERR;
      end
      OFS_MOTOR_TYPE: cfg_d.motor_type = wdata_q[7:0];
      OFS_SECOND_TYPE: cfg_d.second_motor_type = wval;
      OFS_THERM_LVL: begin
        if (ext_open && therm_ok) cfg_d.thermistor_trip_level = wval; // see RL12 see RL18
        else bresp_d = RESP_SLVERR;
      end
      OFS_EXT_DISP: cfg_d.extended_display_select = wdata_q[7:0];
      OFS_SW_FREQ: cfg_d.switching_freq_select = wdata_q[3:0];
      OFS_CONTROL: bresp_d = RESP_OKAY;
      default: bresp_d = RESP_SLVERR;
    endcase
  end

  // Read decode: status shows trips and modes
  always_comb begin
    rdata_d = 32'h0;
    rresp_d = RESP_OKAY;
    case (s_axi_araddr)
      OFS_FIRST_CUR: rdata_d = {16'h0, cfg_q.first_rated_current};
      OFS_SECOND_CUR: rdata_d = {16'h0, cfg_q.second_rated_current};
      OFS_MOTOR_TYPE: rdata_d = {24'h0, cfg_q.motor_type};
      OFS_SECOND_TYPE: rdata_d = {16'h0, cfg_q.second_motor_type};
      OFS_THERM_LVL: rdata_d = {16'h0, cfg_q.thermistor_trip_level};
      OFS_EXT_DISP: rdata_d = {24'h0, cfg_q.extended_display_select};
      OFS_SW_FREQ: rdata_d = {28'h0, cfg_q.switching_freq_select};
      OFS_STATUS: rdata_d = {24'h0, second_mode, first_mode, prealarm_q, therm_trip_q, xstr_trip_q, motor_trip_q};
      OFS_ACCUM: rdata_d = second_set_select ? accum2 : accum1;
      OFS_CONTROL: rdata_d = 32'h0;
      default: rresp_d = RESP_SLVERR;
    endcase
  end

  // AXI write channel: address and data taken in either order
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= bresp_d;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Ready only while the holding slot is empty
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_hold_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_hold_q && !(s_axi_wvalid && s_axi_wready);
    end
  end

  // Settings register; first current resets to drive rating
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cfg_q.first_rated_current <= CUR_RESET; // see RL1
      cfg_q.second_rated_current <= NOT_SET; // see RL4
      cfg_q.motor_type <= 8'h00;
      cfg_q.second_motor_type <= NOT_SET;
      cfg_q.thermistor_trip_level <= NOT_SET; // see RL12
      cfg_q.extended_display_select <= 8'h00;
      cfg_q.switching_freq_select <= 4'h1;
    end else begin
      if (wr_go && bresp_d == RESP_OKAY) cfg_q <= cfg_d;
    end
  end

  // AXI read channel: one-cycle answer after address taken
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !rd_go;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdata_d;
        s_axi_rresp <= rresp_d;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Wrap on the last count keeps the period exact
  wire logic tick_last = (tick_cnt_q == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1));
  // Control tick generator
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= tick_last; // see RL21
      tick_cnt_q <= tick_last ? '0 : tick_cnt_q + 1'b1;
    end
  end

  // Mode selection for both motors; select input from a routed terminal
  mtg_mode_sel u_mode (
    .first_cur(cfg_q.first_rated_current),
    .second_cur(cfg_q.second_rated_current),
    .second_type(cfg_q.second_motor_type),
    .second_set_select(second_set_select), // see RL5 see RL6
    .first_mode(first_mode),
    .second_mode(second_mode)
  );

  // Constant-torque type allows full cooling at low speed, only from 6 Hz
  wire logic ct_type = (cfg_q.motor_type == 8'd1) || (cfg_q.motor_type == 8'd13) ||
                       (cfg_q.motor_type == 8'd50) || (cfg_q.motor_type == 8'd53);
  wire logic low_speed = (output_freq < FREQ_6HZ);
  // Standard motors cool poorly at low speed; smaller leak means faster heating
  wire logic [3:0] motor_shift = (ct_type && !low_speed) ? 4'd6 : (low_speed ? 4'd9 : 4'd7); // see RL16 see RL17
  // Reference for second motor: its current if valid, else the first
  wire logic [15:0] second_ref = (cfg_q.second_rated_current == NOT_SET) ?
                                 cfg_q.first_rated_current : cfg_q.second_rated_current;
  wire logic trip_clear = !reset_in; // see RL14

  // Two motor models
  mtg_integrator u_int1 (
    .core_clk(core_clk), .rst_b(rst_b), .tick(tick_q), .clear(1'b0),
    .mode(first_mode), .rated_cur(cfg_q.first_rated_current), // see RL2
    .meas_cur(output_current), .decay_shift(motor_shift), .accum_q(accum1)
  );
  mtg_integrator u_int2 (
    .core_clk(core_clk), .rst_b(rst_b), .tick(tick_q), .clear(1'b0),
    .mode(second_mode), .rated_cur(second_ref), .meas_cur(output_current),
    .decay_shift(motor_shift), .accum_q(accum2)
  );
  // Transistor model: always active; higher switching frequency leaks less
  mtg_integrator u_xstr (
    .core_clk(core_clk), .rst_b(rst_b), .tick(tick_q), .clear(1'b0),
    .mode(MTG_ACTIVE), .rated_cur(CUR_RESET), .meas_cur(output_current),
    .decay_shift(4'd4 + (cfg_q.switching_freq_select >> 1)), .accum_q(xstr_accum) // see RL15
  );

  // Trip and prealarm levels
  wire logic over1 = (first_mode != MTG_INACTIVE) && (accum1 >= TRIP_LEVEL);
  wire logic over2 = (second_mode != MTG_INACTIVE) && (accum2 >= TRIP_LEVEL);
  wire logic pre = (first_mode != MTG_INACTIVE && accum1 >= PREALARM_LEVEL) ||
                   (second_mode != MTG_INACTIVE && accum2 >= PREALARM_LEVEL);
  wire logic therm_on = (cfg_q.thermistor_trip_level != NOT_SET);
  wire logic motor_trip_d = over1 || over2 || motor_trip_q;
  wire logic xstr_trip_d = (xstr_accum >= XSTR_LEVEL) || xstr_trip_q;
  wire logic therm_trip_d = (therm_on && thermistor_ohms >= cfg_q.thermistor_trip_level) || therm_trip_q;

  // Latched trips and registered prealarm: a new overheat wins over a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      motor_trip_q <= 1'b0;
      xstr_trip_q <= 1'b0;
      therm_trip_q <= 1'b0;
      prealarm_q <= 1'b0;
    end else begin
      motor_trip_q <= (over1 || over2) || (motor_trip_d && !trip_clear); // see RL13 see RL14 see RL19
      xstr_trip_q <= (xstr_accum >= XSTR_LEVEL) || (xstr_trip_d && !trip_clear);
      therm_trip_q <= (therm_on && thermistor_ohms >= cfg_q.thermistor_trip_level) ||
                      (therm_trip_d && !trip_clear); // see RL12
      prealarm_q <= pre; // see RL19 see RL20
    end
  end

  // Outputs straight from flip-flops
  assign motor_overload_trip = motor_trip_q;
  assign transistor_overheat_trip = xstr_trip_q;
  assign thermistor_trip = therm_trip_q;
  assign overload_prealarm_out = prealarm_q;
  always_ff @(posedge core_clk) begin
    if (!rst_b) trip_out <= 1'b0;
    else trip_out <= motor_trip_d || xstr_trip_d || therm_trip_d; // see RL13
  end
endmodule // mtg_guard
`default_nettype wire

//--- test/mtg_guard_sva.sv
// Checker: bus answer and protection properties seen at the guard's ports
`default_nettype none
module mtg_guard_sva
  import mtg_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Register bus
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  // Protection
  input wire logic reset_in,
  input wire logic motor_overload_trip,
  input wire logic overload_prealarm_out,
  input wire logic trip_out
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Read answer comes on the edge after the address is taken
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read answer");
  // Address ready drops for a cycle after each take
  a_ar_gap: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready) else $error("read ready not dropped");
  // Write response within three edges of the data take
  a_write_answer: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("late write answer");
  // Refused reads return zero data
  a_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("nonzero data on refused read");
  a_trip_latched:
    assert property ($fell(motor_overload_trip) |-> !$past(reset_in) || !$past(reset_in, 2) || !$past(reset_in, 3))
    else $error("trip dropped without reset input");
  a_trip_out_or:
    assert property (motor_overload_trip |-> ##[0:1] trip_out) else $error("trip output missing");
  a_prealarm_first:
    assert property ($rose(motor_overload_trip) |-> overload_prealarm_out || $past(overload_prealarm_out))
    else $error("trip without prealarm");
  a_reset_clean:
    assert property ($rose(rst_b) |-> !trip_out && !motor_overload_trip && !overload_prealarm_out)
    else $error("outputs set out of reset");
  // Main scenarios
  c_trip: cover property ($rose(motor_overload_trip));
  c_prealarm: cover property ($rose(overload_prealarm_out));
  c_refused: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule // mtg_guard_sva
bind mtg_guard mtg_guard_sva u_mtg_guard_sva (.core_clk, .rst_b, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .reset_in, .motor_overload_trip,
  .overload_prealarm_out, .trip_out);
`default_nettype wire

//--- test/mtg_meas_model.sv
// Partner model: motor current sensor and terminal inputs
`default_nettype none
module mtg_meas_model (
  // Clock
  input wire logic core_clk,
  // Bench requests
  input wire logic [15:0] cur_req,
  input wire logic sel_req,
  input wire logic rin_req,
  // Measurements and terminals
  output logic [15:0] output_current,
  output logic [15:0] output_freq,
  output logic [15:0] thermistor_ohms,
  output logic second_set_select,
  output logic reset_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Sensor registers once per clock, like a converter output stage
  always_ff @(posedge core_clk) begin
    output_current <= cur_req;     // Measured current
    second_set_select <= sel_req;  // Terminal assigned by code 3
    reset_in <= rin_req;           // Active low trip reset
  end
  // Held above 6 Hz; low-speed derating is not exercised
  assign output_freq = 16'd5000;
  // Cold motor, 1 kohm
  assign thermistor_ohms = 16'd100;
endmodule // mtg_meas_model
`default_nettype wire

//--- test/motor_thermal_overload_guard_tb_top.sv
// Testbench top: register bus tests and overload trip sequence
`default_nettype none
module motor_thermal_overload_guard_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import mtg_pkg::*;
  // Clock, reset and bus master state
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  // Far side requests and wires
  logic [15:0] cur_req = 16'h0;
  logic sel_req = 1'b0, rin_req = 1'b1;
  logic [15:0] output_current, output_freq, thermistor_ohms;
  logic second_set_select, reset_in;
  logic motor_overload_trip, transistor_overheat_trip, thermistor_trip, overload_prealarm_out, trip_out;
  int err_count = 0, total_checks = 0;
  // Mode table: settings and expected {sel on, sel off} mode nibbles {second, first}
  logic [15:0] t_first [6] = '{16'd0, 16'd0, 16'd1000, 16'd1000, 16'd1000, 16'd1000};
  logic [15:0] t_second [6] = '{16'd9999, 16'd100, 16'd9999, 16'd0, 16'd100, 16'd9999};
  logic [15:0] t_type [6] = '{16'd9999, 16'd9999, 16'd9999, 16'd9999, 16'd9999, 16'd1};
  logic [7:0] t_exp [6] = '{8'h00, 8'h84, 8'h22, 8'h12, 8'h96, 8'h96};

  always #5 core_clk = ~core_clk;

  mtg_guard u_mtg_guard (.core_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .output_current,
    .output_freq, .thermistor_ohms, .second_set_select, .reset_in, .motor_overload_trip,
    .transistor_overheat_trip, .thermistor_trip, .overload_prealarm_out, .trip_out);
  mtg_meas_model u_mtg_meas_model (.core_clk, .cur_req, .sel_req, .rin_req, .output_current, .output_freq,
    .thermistor_ohms, .second_set_select, .reset_in);

  // Compare, counted; case equality so unknowns fail
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Write: address and data offered together, each released when taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    while (!s_axi_bvalid) @(posedge core_clk);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    @(posedge core_clk);
  endtask

  // Read: address held until taken, rready held until data seen
  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    chk("rdata", ed, s_axi_rdata);
    @(posedge core_clk);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Watchdog: tests need about 20k cycles
  initial begin
    repeat (60000) @(posedge core_clk);
    err_count++;
    finish_test();
  end

  initial begin
    int n;
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    // Reset values
    axi_read(OFS_FIRST_CUR, {16'h0, CUR_RESET}, RESP_OKAY);
    axi_read(OFS_SECOND_CUR, {16'h0, NOT_SET}, RESP_OKAY);
    axi_read(OFS_THERM_LVL, {16'h0, NOT_SET}, RESP_OKAY);
    axi_read(OFS_SECOND_TYPE, {16'h0, NOT_SET}, RESP_OKAY);
    axi_read(OFS_MOTOR_TYPE, 32'h0, RESP_OKAY);
    axi_read(OFS_EXT_DISP, 32'h0, RESP_OKAY);
    axi_read(OFS_SW_FREQ, 32'h1, RESP_OKAY);
    axi_read(OFS_STATUS, 32'h20, RESP_OKAY);
    $display("test reset_values done");
    // Ranges, write lock and unmapped space
    axi_write(OFS_FIRST_CUR, 32'd50001, RESP_SLVERR);
    axi_write(OFS_FIRST_CUR, 32'd50000, RESP_OKAY);
    axi_read(OFS_FIRST_CUR, 32'd50000, RESP_OKAY);
    axi_write(OFS_SECOND_CUR, 32'd50001, RESP_SLVERR);
    axi_write(OFS_THERM_LVL, 32'd49, RESP_SLVERR);
    axi_write(OFS_THERM_LVL, 32'd3000, RESP_OKAY);
    axi_write(OFS_EXT_DISP, 32'h1, RESP_OKAY);
    axi_write(OFS_SECOND_CUR, 32'd100, RESP_SLVERR);
    axi_write(OFS_THERM_LVL, 32'd50, RESP_SLVERR);
    axi_write(OFS_EXT_DISP, 32'h0, RESP_OKAY);
    axi_read(OFS_THERM_LVL, 32'd3000, RESP_OKAY);
    axi_write(8'h28, 32'h1, RESP_SLVERR);
    axi_read(8'h28, 32'h0, RESP_SLVERR);
    $display("test access_rules done");
    // Mode per motor for every setting row and select level
    for (int i = 0; i < 6; i++) begin
      axi_write(OFS_FIRST_CUR, {16'h0, t_first[i]}, RESP_OKAY);
      axi_write(OFS_SECOND_CUR, {16'h0, t_second[i]}, RESP_OKAY);
      axi_write(OFS_SECOND_TYPE, {16'h0, t_type[i]}, RESP_OKAY);
      for (int s = 0; s < 2; s++) begin
        sel_req <= s[0];
        repeat (4) @(posedge core_clk);
        axi_read(OFS_STATUS, {24'h0, (s == 1) ? t_exp[i][7:4] : t_exp[i][3:0], 4'h0}, RESP_OKAY);
      end
    end
    sel_req <= 1'b0;
    $display("test mode_table done");
    // First set disabled: heavy current must not heat it
    axi_write(OFS_SECOND_TYPE, {16'h0, NOT_SET}, RESP_OKAY);
    axi_write(OFS_FIRST_CUR, 32'h0, RESP_OKAY);
    cur_req <= CUR_MAX;
    repeat (TICK_CYCLES + 1000) @(posedge core_clk);
    chk("prealarm", 32'h0, {31'h0, overload_prealarm_out});
    chk("motor_trip", 32'h0, {31'h0, motor_overload_trip});
    // Tiny rating: trips within a couple of ticks
    axi_write(OFS_FIRST_CUR, 32'd1, RESP_OKAY);
    n = 0;
    while (motor_overload_trip !== 1'b1 && n < 2 * TICK_CYCLES) begin
      @(posedge core_clk);
      n++;
    end
    repeat (2) @(posedge core_clk);
    chk("motor_trip", 32'h1, {31'h0, motor_overload_trip});
    chk("prealarm", 32'h1, {31'h0, overload_prealarm_out});
    chk("trip_out", 32'h1, {31'h0, trip_out});
    cur_req <= 16'h0;
    axi_write(OFS_FIRST_CUR, 32'h0, RESP_OKAY);
    repeat (20) @(posedge core_clk);
    chk("motor_trip", 32'h1, {31'h0, motor_overload_trip});
    rin_req <= 1'b0;
    repeat (5) @(posedge core_clk);
    rin_req <= 1'b1;
    repeat (5) @(posedge core_clk);
    chk("motor_trip", 32'h0, {31'h0, motor_overload_trip});
    chk("trip_out", 32'h0, {31'h0, trip_out});
    chk("xstr_trip", 32'h0, {31'h0, transistor_overheat_trip});
    chk("therm_trip", 32'h0, {31'h0, thermistor_trip});
    $display("test overload_trip done");
    finish_test();
  end
endmodule // motor_thermal_overload_guard_tb_top
`default_nettype wire
